// ===== rtl/bts_sequencer.v
// Built-in test sequencer: power-up, confidence and full tests behind APB.
`timescale 1ns/1ns
`include "bts_consts.vh"
// Functional notes
// - Confidence result zero on pass, else 1..31.
// - Commanded subtests 0..5 run despite earlier failures.
// - Each failing subtest sets its own bit.
// - Bits 0..4: program, working, flash, optical, potentiometer.
// - Full test adds bits 5..9.
// - Power-up failure sounds subtest beep code.
// - Failed power-up subtest repeats until it passes.
// - All-ones selector skips power-up test.
// - Bypass beeps evenly until valid address.
// - Baud rate decoded from the whole selector value.
// - Confidence test never touches supply output.
// - Uncalibrated card reports flash error.
// - Output driven only after internal checks pass.
// - Current mode limit, then readback scales.
// - Failures go to error queue; subtest 0..5 failures also beep if the beeper is idle.
// - Uninitialized card beeps three times.
module bts_sequencer #(
  parameter BEEP_CYC = `BTS_BEEP_MS * `BTS_CLK_KHZ,
  parameter SW_W = 5
) (
  input wire SYS_CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [SW_W-1:0] ADDRESS_SELECTOR_SWITCH,
  input wire CARD_UNINIT,
  input wire CAL_VALID,
  output reg SUBTEST_REQ,
  output reg [3:0] SUBTEST_ID,
  input wire SUBTEST_DONE,
  input wire SUBTEST_FAIL,
  output reg OUT_TEST_OWN,
  output reg OUT_CURRENT_MODE,
  output reg ERRQ_PUSH,
  output reg [3:0] ERRQ_CODE,
  output reg [1:0] BAUD_SEL,
  output reg BEEP,
  output reg IRQ
);
  localparam [9:0] S_BOOT = 10'h001;
  localparam [9:0] S_BYPASS = 10'h002;
  localparam [9:0] S_PUP_REQ = 10'h004;
  localparam [9:0] S_PUP_WAIT = 10'h008;
  localparam [9:0] S_PUP_BEEP = 10'h010;
  localparam [9:0] S_INIT_BEEP = 10'h020;
  localparam [9:0] S_IDLE = 10'h040;
  localparam [9:0] S_CMD_REQ = 10'h080;
  localparam [9:0] S_CMD_WAIT = 10'h100;
  localparam [9:0] S_PUP_GAP = 10'h200;

  wire [SW_W-1:0] sw_s;
  wire [1:0] uninit_cal_s;
  wire beep_w;
  wire beep_busy;
  reg [9:0] state_q;
  reg [2:0] boot_q;
  reg [3:0] step_q;
  reg [3:0] last_q;
  reg full_q;
  reg [9:0] err_q;
  reg [9:0] result_q;
  reg busy_q;
  reg done_q;
  reg bypass_q;
  reg pup_ok_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_en_q;
  reg [2:0] ev;
  reg beep_start;
  reg [2:0] beep_cnt;
  reg beep_cont_q;
  reg req_conf;
  reg req_full;
  reg fail_now;
  reg [31:0] rd_d;
  reg rd_err;
  wire apb_first;
  wire apb_acc;

  bts_sync #(.W(SW_W)) u_sw_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .d(ADDRESS_SELECTOR_SWITCH),
    .q(sw_s)
  );

  bts_sync #(.W(2)) u_flag_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .d({CARD_UNINIT, CAL_VALID}),
    .q(uninit_cal_s)
  );

  bts_beeper #(.TICK_CYC(BEEP_CYC), .CW(24)) u_beeper (
    .clk(SYS_CLK),
    .nrst(NRST),
    .start(beep_start),
    .count(beep_cnt),
    .cont(beep_cont_q),
    .beep(beep_w),
    .busy(beep_busy)
  );

  function [2:0] beep_code;
    input [3:0] id;
    begin
      case (id)
        `BTS_ID_ROM: beep_code = `BTS_BEEP_MEM;
        `BTS_ID_RAM: beep_code = `BTS_BEEP_MEM;
        `BTS_ID_FLASH: beep_code = `BTS_BEEP_FLASH;
        `BTS_ID_OPT: beep_code = `BTS_BEEP_OPT;
        `BTS_ID_POT: beep_code = `BTS_BEEP_POT;
        `BTS_ID_LOOP: beep_code = `BTS_BEEP_LOOP;
        default: beep_code = `BTS_BEEP_NONE;
      endcase
    end
  endfunction

  // APB access completes with one wait state.
  assign apb_first = PSEL && PENABLE && !PREADY;
  assign apb_acc = PSEL && PENABLE && PREADY;

  always @* begin
    rd_d = 32'h0000_0000;
    rd_err = 1'b0;
    case (PADDR)
      `BTS_REG_CTRL: rd_d = 32'h0000_0000;
      `BTS_REG_STATUS: rd_d = {26'h0, BAUD_SEL, pup_ok_q, bypass_q, done_q, busy_q};
      `BTS_REG_RESULT: rd_d = {22'h0, result_q};
      `BTS_REG_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
      `BTS_REG_IRQ_CLR: rd_d = 32'h0000_0000;
      `BTS_REG_IRQ_EN: rd_d = {29'h0, irq_en_q};
      default: rd_err = 1'b1;
    endcase
  end

  always @* begin
    req_conf = 1'b0;
    req_full = 1'b0;
    if (apb_acc && PWRITE && PADDR == `BTS_REG_CTRL) begin
      req_conf = PWDATA[`BTS_CTRL_CONF];
      req_full = PWDATA[`BTS_CTRL_FULL] && !PWDATA[`BTS_CTRL_CONF];
    end
  end

  // Uncalibrated card always fails the flash subtest.
  always @* begin
    fail_now = SUBTEST_FAIL;
    if (SUBTEST_ID == `BTS_ID_FLASH && !uninit_cal_s[0]) begin
      fail_now = 1'b1;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      irq_en_q <= 3'h0;
      irq_stat_q <= 3'h0;
      IRQ <= 1'b0;
      BEEP <= 1'b0;
    end else begin
      PREADY <= apb_first;
      if (apb_first) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_d;
        PSLVERR <= rd_err;
      end
      if (apb_acc && PWRITE && PADDR == `BTS_REG_IRQ_EN) begin
        irq_en_q <= PWDATA[2:0];
      end
      if (apb_acc && PWRITE && PADDR == `BTS_REG_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~PWDATA[2:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      IRQ <= |(irq_stat_q & irq_en_q);
      BEEP <= beep_w;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= S_BOOT;
      boot_q <= 3'h0;
      step_q <= 4'h0;
      last_q <= 4'h0;
      full_q <= 1'b0;
      err_q <= 10'h000;
      result_q <= 10'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      bypass_q <= 1'b0;
      pup_ok_q <= 1'b0;
      beep_start <= 1'b0;
      beep_cnt <= 3'h0;
      beep_cont_q <= 1'b0;
      ev <= 3'h0;
      SUBTEST_REQ <= 1'b0;
      SUBTEST_ID <= 4'h0;
      OUT_TEST_OWN <= 1'b0;
      OUT_CURRENT_MODE <= 1'b0;
      ERRQ_PUSH <= 1'b0;
      ERRQ_CODE <= 4'h0;
      BAUD_SEL <= `BTS_BAUD_9600;
    end else begin
      beep_start <= 1'b0;
      ev <= 3'h0;
      SUBTEST_REQ <= 1'b0;
      ERRQ_PUSH <= 1'b0;
      case (sw_s)
        `BTS_SW_B19200: BAUD_SEL <= `BTS_BAUD_19200;
        `BTS_SW_B38400: BAUD_SEL <= `BTS_BAUD_38400;
        `BTS_SW_B9600: BAUD_SEL <= `BTS_BAUD_9600;
        default: BAUD_SEL <= `BTS_BAUD_9600;
      endcase
      case (state_q)
        S_BOOT: begin
          boot_q <= boot_q + 3'h1;
          if (boot_q == `BTS_BOOT_CYC) begin
            if (sw_s == `BTS_SW_BYPASS) begin
              bypass_q <= 1'b1;
              beep_cont_q <= 1'b1;
              state_q <= S_BYPASS;
            end else begin
              step_q <= `BTS_ID_ROM;
              state_q <= S_PUP_REQ;
            end
          end
        end
        S_BYPASS: begin
          if (sw_s != `BTS_SW_BYPASS) begin
            beep_cont_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_PUP_REQ: begin
          SUBTEST_REQ <= 1'b1;
          SUBTEST_ID <= step_q;
          state_q <= S_PUP_WAIT;
        end
        S_PUP_WAIT: begin
          if (SUBTEST_DONE) begin
            if (fail_now) begin
              ERRQ_PUSH <= 1'b1;
              ERRQ_CODE <= step_q;
              beep_start <= 1'b1;
              beep_cnt <= beep_code(step_q);
              ev[`BTS_EV_PUP] <= 1'b1;
              state_q <= S_PUP_GAP;
            end else if (step_q == `BTS_LAST_PUP) begin
              pup_ok_q <= 1'b1;
              if (uninit_cal_s[1]) begin
                beep_start <= 1'b1;
                beep_cnt <= `BTS_BEEP_INIT;
                state_q <= S_INIT_BEEP;
              end else begin
                state_q <= S_IDLE;
              end
            end else begin
              step_q <= step_q + 4'h1;
              state_q <= S_PUP_REQ;
            end
          end
        end
        S_PUP_GAP: begin
          state_q <= S_PUP_BEEP;
        end
        S_PUP_BEEP: begin
          if (!beep_busy) begin
            state_q <= S_PUP_REQ;
          end
        end
        S_INIT_BEEP: begin
          if (!beep_busy) begin
            state_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (req_conf || req_full) begin
            err_q <= 10'h000;
            full_q <= req_full;
            last_q <= req_full ? `BTS_LAST_FULL : `BTS_LAST_CONF;
            step_q <= `BTS_ID_ROM;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            state_q <= S_CMD_REQ;
          end
        end
        S_CMD_REQ: begin
          SUBTEST_REQ <= 1'b1;
          SUBTEST_ID <= step_q;
          OUT_TEST_OWN <= full_q && step_q >= `BTS_ID_MAXV;
          OUT_CURRENT_MODE <= full_q && step_q == `BTS_ID_QSV;
          state_q <= S_CMD_WAIT;
        end
        S_CMD_WAIT: begin
          if (SUBTEST_DONE) begin
            OUT_TEST_OWN <= 1'b0;
            OUT_CURRENT_MODE <= 1'b0;
            if (fail_now) begin
              err_q[step_q] <= 1'b1;
              ERRQ_PUSH <= 1'b1;
              ERRQ_CODE <= step_q;
              beep_start <= 1'b1;
              beep_cnt <= beep_code(step_q);
            end
            if (step_q == last_q ||
                (step_q == `BTS_ID_LOOP && (fail_now || err_q[5:0] != 6'h00))) begin
              // Output steps are skipped after an internal check fails.
              result_q <= fail_now ? (err_q | (10'h001 << step_q)) : err_q;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              ev[`BTS_EV_DONE] <= 1'b1;
              ev[`BTS_EV_FAIL] <= fail_now || err_q != 10'h000;
              state_q <= S_IDLE;
            end else begin
              step_q <= step_q + 4'h1;
              state_q <= S_CMD_REQ;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== rtl/bts_consts.vh
// Constants shared by the built-in test sequencer files.
`ifndef BTS_CONSTS_VH
`define BTS_CONSTS_VH
`define BTS_CLK_KHZ 125000
`define BTS_BEEP_MS 100
`define BTS_BOOT_CYC 3'h4
`define BTS_REG_CTRL 8'h00
`define BTS_REG_STATUS 8'h04
`define BTS_REG_RESULT 8'h08
`define BTS_REG_IRQ_STAT 8'h0c
`define BTS_REG_IRQ_CLR 8'h10
`define BTS_REG_IRQ_EN 8'h14
`define BTS_CTRL_CONF 0
`define BTS_CTRL_FULL 1
`define BTS_EV_DONE 0
`define BTS_EV_FAIL 1
`define BTS_EV_PUP 2
`define BTS_ID_ROM 4'h0
`define BTS_ID_RAM 4'h1
`define BTS_ID_FLASH 4'h2
`define BTS_ID_OPT 4'h3
`define BTS_ID_POT 4'h4
`define BTS_ID_LOOP 4'h5
`define BTS_ID_MAXV 4'h6
`define BTS_ID_MINV 4'h7
`define BTS_ID_QSV 4'h8
`define BTS_ID_QSRB 4'h9
`define BTS_LAST_CONF 4'h4
`define BTS_LAST_FULL 4'h9
`define BTS_LAST_PUP 4'h5
`define BTS_BEEP_MEM 3'h1
`define BTS_BEEP_FLASH 3'h2
`define BTS_BEEP_OPT 3'h3
`define BTS_BEEP_POT 3'h6
`define BTS_BEEP_LOOP 3'h5
`define BTS_BEEP_INIT 3'h3
`define BTS_BEEP_NONE 3'h0
`define BTS_SW_BYPASS 5'h1f
`define BTS_SW_B9600 5'h06
`define BTS_SW_B19200 5'h01
`define BTS_SW_B38400 5'h03
`define BTS_BAUD_9600 2'h0
`define BTS_BAUD_19200 2'h1
`define BTS_BAUD_38400 2'h2
`endif

// ===== rtl/bts_sync.v
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ns
module bts_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ===== rtl/bts_beeper.v
// Beep generator: a counted burst or an endless equal on/off pattern.
`timescale 1ns/1ns
module bts_beeper #(
  parameter TICK_CYC = 12500000,
  parameter CW = 24
) (
  input wire clk,
  input wire nrst,
  input wire start,
  input wire [2:0] count,
  input wire cont,
  output reg beep,
  output reg busy
);
  reg [CW-1:0] cnt_q;
  reg [3:0] left_q;
  wire tick;
  assign tick = (cnt_q == TICK_CYC[CW-1:0] - 1'b1);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= {CW{1'b0}};
      left_q <= 4'h0;
      beep <= 1'b0;
      busy <= 1'b0;
    end else if (start && !busy && count != 3'h0) begin
      cnt_q <= {CW{1'b0}};
      left_q <= {count, 1'b0};
      beep <= 1'b1;
      busy <= 1'b1;
    end else if (busy || cont) begin
      cnt_q <= tick ? {CW{1'b0}} : cnt_q + 1'b1;
      if (tick && busy) begin
        if (left_q == 4'h1) begin
          busy <= 1'b0;
          beep <= 1'b0;
        end else begin
          left_q <= left_q - 1'b1;
          beep <= ~beep;
        end
      end else if (tick) begin
        beep <= ~beep;
      end
    end else begin
      cnt_q <= {CW{1'b0}};
      beep <= 1'b0;
    end
  end
endmodule

// ===== verif/bts_checker.sv
// Port assertions for the built-in test sequencer.
`timescale 1ns/1ns
`include "bts_consts.vh"
module bts_checker (
  input wire SYS_CLK,
  input wire NRST,
  input wire PREADY,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PRDATA,
  input wire SUBTEST_REQ,
  input wire [3:0] SUBTEST_ID,
  input wire SUBTEST_DONE,
  input wire SUBTEST_FAIL,
  input wire OUT_TEST_OWN,
  input wire OUT_CURRENT_MODE,
  input wire ERRQ_PUSH,
  input wire [3:0] ERRQ_CODE
);
  reg wait_q;
  wire fin = wait_q && SUBTEST_DONE;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // Marks the span between a subtest request and its answer.
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wait_q <= 1'b0;
    end else if (SUBTEST_REQ) begin
      wait_q <= 1'b1;
    end else if (SUBTEST_DONE) begin
      wait_q <= 1'b0;
    end
  end
  AST_ERRQ_PUSH: assert property (fin && SUBTEST_FAIL |=> ERRQ_PUSH && ERRQ_CODE == $past(SUBTEST_ID))
    else $error("failed subtest not queued");
  AST_PASS_QUIET: assert property (fin && !SUBTEST_FAIL && SUBTEST_ID != 4'h2 |=> !ERRQ_PUSH)
    else $error("passing subtest queued");
  AST_RUN_ON: assert property (fin && !SUBTEST_FAIL && SUBTEST_ID < 4'h4 |-> ##[1:2] SUBTEST_REQ)
    else $error("sequence stopped early");
  AST_HOLD_WAIT: assert property (wait_q && !SUBTEST_DONE |-> !SUBTEST_REQ)
    else $error("request while waiting");
  AST_OWN_LOW: assert property (SUBTEST_REQ && SUBTEST_ID < 4'h6 |-> !OUT_TEST_OWN)
    else $error("output taken too early");
  AST_OWN_HIGH: assert property (SUBTEST_REQ && SUBTEST_ID > 4'h5 |-> ##[0:1] OUT_TEST_OWN)
    else $error("output not taken");
  AST_CUR_MODE: assert property (SUBTEST_REQ && SUBTEST_ID == 4'h8 |-> ##[0:1] OUT_CURRENT_MODE)
    else $error("current mode missing");
  AST_ID_RANGE: assert property (SUBTEST_REQ |-> SUBTEST_ID <= `BTS_LAST_FULL)
    else $error("subtest id out of range");
  AST_RESULT_RANGE: assert property (PREADY && !PWRITE && PADDR == `BTS_REG_RESULT |-> PRDATA[31:10] == 22'h0)
    else $error("result above ten bits");
endmodule

// ===== verif/bts_subtest_model.sv
// Subtest hardware model answering each request after a set delay.
`timescale 1ns/1ns
module bts_subtest_model (
  input wire clk,
  input wire nrst,
  input wire req,
  input wire [3:0] id,
  input wire [9:0] fail_mask,
  input wire [3:0] delay,
  output reg done,
  output reg fail,
  output reg [7:0] req_cnt
);
  reg busy_q;
  reg [3:0] cnt_q;
  reg [3:0] id_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      fail <= 1'b0;
      req_cnt <= 8'h0;
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      id_q <= 4'h0;
    end else begin
      done <= 1'b0;
      // The fail line carries no meaning outside done, so it keeps toggling.
      fail <= ~fail;
      if (req) begin
        busy_q <= 1'b1;
        cnt_q <= delay;
        id_q <= id;
        req_cnt <= req_cnt + 8'h1;
      end else if (busy_q && cnt_q == 4'h0) begin
        done <= 1'b1;
        fail <= fail_mask[id_q];
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// ===== verif/test_built_in_test_sequencer.sv
// Self-checking bench for the built-in test sequencer.
`timescale 1ns/1ns
`include "bts_consts.vh"
module test_built_in_test_sequencer;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, req, done, fail, own, cur, push, beep, irq;
  logic [4:0] sw = 5'h1f;
  logic cal_ok = 1'b1;
  logic uninit = 1'b0;
  logic [3:0] id, code;
  logic [3:0] last_code = 4'h0;
  logic [1:0] baud;
  logic [9:0] fail_mask = 10'h0;
  logic [3:0] delay = 4'h0;
  logic [7:0] req_cnt;
  logic own_seen = 1'b0;
  logic [7:0] beeps = 8'h0;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int tests_run = 0;
  bts_sequencer #(.BEEP_CYC(8), .SW_W(5)) i_dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ADDRESS_SELECTOR_SWITCH(sw), .CARD_UNINIT(uninit), .CAL_VALID(cal_ok),
    .SUBTEST_REQ(req), .SUBTEST_ID(id), .SUBTEST_DONE(done), .SUBTEST_FAIL(fail),
    .OUT_TEST_OWN(own), .OUT_CURRENT_MODE(cur), .ERRQ_PUSH(push), .ERRQ_CODE(code),
    .BAUD_SEL(baud), .BEEP(beep), .IRQ(irq));
  bts_subtest_model i_host (.clk(sys_clk), .nrst(nrst), .req(req), .id(id),
    .fail_mask(fail_mask), .delay(delay), .done(done), .fail(fail), .req_cnt(req_cnt));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge own) own_seen = 1'b1;
  always @(posedge beep) beeps = beeps + 8'h1;
  always @(posedge sys_clk) if (push === 1'b1) last_code <= code;
  task automatic end_of_test;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) mismatches++;
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 300) begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    chk(rd[b], 1'b1);
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    beeps = 8'h0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  task automatic run(input logic [31:0] ctl, input logic [9:0] m, input logic [31:0] res,
                     input logic [7:0] reqs, input logic own_exp);
    logic [7:0] start;
    fail_mask <= m;
    own_seen = 1'b0;
    apb(1'b1, `BTS_REG_IRQ_CLR, 32'h7);
    start = req_cnt;
    apb(1'b1, `BTS_REG_CTRL, ctl);
    poll(`BTS_REG_IRQ_STAT, `BTS_EV_DONE);
    apb(1'b0, `BTS_REG_RESULT, 32'h0);
    chk(rd, res);
    chk(req_cnt - start, reqs);
    chk(own_seen, own_exp);
  endtask
  task automatic t_bypass;
    do_reset;
    repeat (100) @(posedge sys_clk);
    chk(req_cnt, 8'h0);
    chk(beeps > 8'h3, 1'b1);
    sw <= `BTS_SW_B19200;
    repeat (20) @(posedge sys_clk);
    chk(beep, 1'b0);
    chk(baud, `BTS_BAUD_19200);
    $display("test bypass done");
  endtask
  task automatic t_powerup;
    int n;
    n = 0;
    sw <= `BTS_SW_B38400;
    fail_mask <= 10'h008;
    delay <= 4'h3;
    uninit <= 1'b1;
    do_reset;
    while (req_cnt < 8'h5 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(id, `BTS_ID_OPT);
    chk(beeps, `BTS_BEEP_OPT);
    chk(last_code, `BTS_ID_OPT);
    fail_mask <= 10'h0;
    poll(`BTS_REG_STATUS, 3);
    chk(req_cnt, 8'h7);
    chk(baud, `BTS_BAUD_38400);
    repeat (100) @(posedge sys_clk);
    chk(beeps, 8'h6);
    uninit <= 1'b0;
    $display("test powerup done");
  endtask
  task automatic t_tests;
    run(32'h1, 10'h00a, 32'h00a, 8'h5, 1'b0);
    run(32'h1, 10'h3e0, 32'h0, 8'h5, 1'b0);
    delay <= 4'h3;
    run(32'h2, 10'h280, 32'h280, 8'ha, 1'b1);
    run(32'h2, 10'h011, 32'h011, 8'h6, 1'b0);
    delay <= 4'h0;
    cal_ok <= 1'b0;
    run(32'h1, 10'h0, 32'h004, 8'h5, 1'b0);
    cal_ok <= 1'b1;
    $display("test commanded done");
  endtask
  task automatic t_irq;
    apb(1'b1, `BTS_REG_IRQ_EN, 32'h2);
    run(32'h1, 10'h001, 32'h001, 8'h5, 1'b0);
    chk(irq, 1'b1);
    apb(1'b1, `BTS_REG_IRQ_CLR, 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    chk(irq, 1'b0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    sw <= `BTS_SW_B9600;
    repeat (6) @(posedge sys_clk);
    chk(baud, `BTS_BAUD_9600);
    $display("test irq done");
  endtask
  initial begin
    t_bypass;
    t_powerup;
    t_tests;
    t_irq;
    end_of_test;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    end_of_test;
  end
endmodule
bind bts_sequencer bts_checker i_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .PREADY(PREADY),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .SUBTEST_REQ(SUBTEST_REQ),
  .SUBTEST_ID(SUBTEST_ID), .SUBTEST_DONE(SUBTEST_DONE), .SUBTEST_FAIL(SUBTEST_FAIL),
  .OUT_TEST_OWN(OUT_TEST_OWN), .OUT_CURRENT_MODE(OUT_CURRENT_MODE),
  .ERRQ_PUSH(ERRQ_PUSH), .ERRQ_CODE(ERRQ_CODE));
